// *** hdl/cfb_pkg.sv ***
// Purpose: state types of the serial link, each used by one end only
// Assumes: nothing beyond the constants header
// Notes:   state encodings are left to the tools
package cfb_pkg;
  typedef enum logic [2:0] {D_IDLE, D_RX, D_RX_ACK, D_TX, D_TX_ACK} cfb_dst_e;
  typedef enum logic [2:0] {P_ADDR, P_CMD, P_WCNT, P_WDATA, P_RCNT,
                            P_RDATA} cfb_dph_e;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} cfb_hst_e;
endpackage

// *** hdl/cfb_smb_dev.sv ***
// Purpose: serial target with block write and block read of registers
// Assumes: scl and sda arrive synchronous to clk, far slower than it
// Notes:   no clock stretching; one register bank of N_REGS bytes
`timescale 1ns/100ps
`include "cfb_smb_regs.svh"
module cfb_smb_dev #(
  parameter int N_REGS = 3,
  parameter int PTR_W  = 2
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  cfb_smb_if.dev                   bus,
  output logic [N_REGS*8-1:0]      bank,
  output logic                     wr_stb,
  output logic [PTR_W-1:0]         wr_idx
);

  typedef struct packed {
    logic                    scl;
    logic                    sda;
    cfb_pkg::cfb_dst_e       st;
    cfb_pkg::cfb_dph_e       ph;
    logic [3:0]              cnt;
    logic [7:0]              sh;
    logic [PTR_W-1:0]        ptr;
    logic                    drv;
    logic                    ack;
    logic                    wr;
    logic [PTR_W-1:0]        widx;
    logic [N_REGS-1:0][7:0]  regs;
  } cfb_dev_s;

  cfb_dev_s   q;
  cfb_dev_s   n;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       load;

  // pointer step, shared by write and read paths
  function automatic logic [PTR_W-1:0] ptr_next(
    input logic [PTR_W-1:0] p
  );
    logic [PTR_W-1:0] r;
    r = p + {{(PTR_W-1){1'b0}}, 1'b1};
    if (p == PTR_W'(N_REGS - 1))
    begin
      r = '0;
    end
    return r;
  endfunction

  // line events, judged against last sampled levels
  assign rise  = ~q.scl & bus.scl;
  assign fall  = q.scl & ~bus.scl;
  assign start = q.scl & bus.scl & q.sda & ~bus.sda;
  assign stop  = q.scl & bus.scl & ~q.sda & bus.sda;

  // next state of the whole target
  always_comb
  begin
    n     = q;
    load  = 1'b0;
    n.scl = bus.scl;
    n.sda = bus.sda;
    n.wr  = 1'b0;
    if (start)
    begin
      n.st  = cfb_pkg::D_RX;
      n.ph  = cfb_pkg::P_ADDR;
      n.cnt = 4'h0;
      n.drv = 1'b0;
    end
    else if (stop)
    begin
      n.st  = cfb_pkg::D_IDLE;
      n.drv = 1'b0;
    end
    else
    begin
      case (q.st)
        cfb_pkg::D_IDLE:
        begin
          n.drv = 1'b0;
        end
        cfb_pkg::D_RX:
        begin
          if (rise)
          begin
            n.sh  = {q.sh[6:0], bus.sda};
            n.cnt = q.cnt + 4'h1;
          end
          if (fall && q.cnt == 4'h8)
          begin
            n.cnt = 4'h0;
            n.st  = cfb_pkg::D_RX_ACK;
            n.drv = 1'b1;
            case (q.ph)
              cfb_pkg::P_ADDR:
              begin
                if (q.sh[7:1] != `CFB_DEV_ADDR)
                begin
                  n.st  = cfb_pkg::D_IDLE;
                  n.drv = 1'b0;
                end
                else if (q.sh[0] == `CFB_RW_WRITE)
                begin
                  n.ptr = '0;
                  n.ph  = cfb_pkg::P_CMD;
                end
                else
                begin
                  n.ph = cfb_pkg::P_RCNT;
                end
              end
              cfb_pkg::P_CMD:
              begin
                if (q.sh != `CFB_CMD_CODE)
                begin
                  n.st  = cfb_pkg::D_IDLE;
                  n.drv = 1'b0;
                end
                else
                begin
                  n.ph = cfb_pkg::P_WCNT;
                end
              end
              cfb_pkg::P_WCNT:
              begin
                n.ph = cfb_pkg::P_WDATA;
              end
              cfb_pkg::P_WDATA:
              begin
                n.regs[q.ptr] = q.sh;
                n.wr          = 1'b1;
                n.widx        = q.ptr;
                n.ptr         = ptr_next(q.ptr);
              end
              cfb_pkg::P_RCNT:
              begin
                n.ph = cfb_pkg::P_RDATA;
              end
              default:
              begin
                n.ph = q.ph;
              end
            endcase
          end
        end
        cfb_pkg::D_RX_ACK:
        begin
          if (fall)
          begin
            n.drv = 1'b0;
            if (q.ph == cfb_pkg::P_RDATA)
            begin
              load = 1'b1;
            end
            else
            begin
              n.st = cfb_pkg::D_RX;
            end
          end
        end
        cfb_pkg::D_TX:
        begin
          if (rise)
          begin
            n.cnt = q.cnt + 4'h1;
          end
          if (fall)
          begin
            if (q.cnt == 4'h8)
            begin
              // release so host can answer
              n.st  = cfb_pkg::D_TX_ACK;
              n.drv = 1'b0;
            end
            else
            begin
              n.sh  = {q.sh[6:0], 1'b0};
              n.drv = ~q.sh[6];
            end
          end
        end
        cfb_pkg::D_TX_ACK:
        begin
          if (rise)
          begin
            n.ack = ~bus.sda;
          end
          if (fall)
          begin
            if (q.ack)
            begin
              load = 1'b1;
            end
            else
            begin
              n.st  = cfb_pkg::D_IDLE;
              n.drv = 1'b0;
            end
          end
        end
        default:
        begin
          n.st  = cfb_pkg::D_IDLE;
          n.drv = 1'b0;
        end
      endcase
    end
    if (load)
    begin
      n.st  = cfb_pkg::D_TX;
      n.cnt = 4'h0;
      n.sh  = q.regs[q.ptr];
      n.drv = ~q.regs[q.ptr][7];
      n.ptr = ptr_next(q.ptr);
    end
  end

  // one register for all state; idle lines read high
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q      <= '0;
      q.scl  <= 1'b1;
      q.sda  <= 1'b1;
      q.regs <= {N_REGS{`CFB_REG_RST}};
    end
    else if (clk_en)
    begin
      q <= n;
    end
  end

  // open drain: value fixed low, enable does the work
  assign bus.dsda_o  = 1'b0;
  assign bus.dsda_oe = q.drv;
  assign bank        = q.regs;
  assign wr_stb      = q.wr;
  assign wr_idx      = q.widx;

endmodule

// *** hdl/cfb_smb_host.sv ***
// Purpose: bus master issuing block writes and block reads
// Assumes: target never stretches the clock
// Notes:   each bit is four quarter periods of QTR cycles
`timescale 1ns/100ps
`include "cfb_smb_regs.svh"
module cfb_smb_host #(
  parameter int RATE_KBPS = `CFB_RATE_KBPS,
  parameter int QTR       = `CFB_QTR_CYC(RATE_KBPS),
  parameter int LEN_W     = 6
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  cfb_smb_if.host               bus,
  input  wire logic             go,
  input  wire logic             rd,
  input  wire logic [LEN_W-1:0] len,
  input  wire logic [7:0]       wdata,
  output logic                  wtake,
  output logic [7:0]            rdata,
  output logic                  rvalid,
  output logic                  busy,
  output logic                  nack_err
);

  typedef struct packed {
    cfb_pkg::cfb_hst_e  st;
    logic [15:0]        qc;
    logic [1:0]         ph;
    logic [3:0]         bi;
    logic [7:0]         sh;
    logic [2:0]         step;
    logic [LEN_W-1:0]   rem;
    logic [LEN_W-1:0]   len;
    logic               rd;
    logic               rx;
    logic               nak;
    logic               sclo;
    logic               sdao;
    logic [7:0]         rdata;
    logic               rvalid;
    logic               take;
    logic               err;
  } cfb_host_s;

  cfb_host_s  q;
  cfb_host_s  n;
  logic       tick;

  assign tick = (q.qc == 16'(QTR - 1));

  // header byte sent at each step
  function automatic logic [7:0] hdr_byte(
    input logic [2:0]       s,
    input logic             r,
    input logic [LEN_W-1:0] l
  );
    logic [7:0] b;
    b = 8'(l);
    case (s)
      3'h0: b = {`CFB_DEV_ADDR, `CFB_RW_WRITE};
      3'h1: b = `CFB_CMD_CODE;
      3'h2: b = r ? {`CFB_DEV_ADDR, `CFB_RW_READ} : 8'(l);
      default: b = 8'(l);
    endcase
    return b;
  endfunction

  // sequencer: start, bytes with ack, stop
  always_comb
  begin
    n        = q;
    n.rvalid = 1'b0;
    n.take   = 1'b0;
    if (q.st == cfb_pkg::H_IDLE)
    begin
      n.sclo = 1'b0;
      n.sdao = 1'b0;
      if (go)
      begin
        n.st   = cfb_pkg::H_START;
        n.qc   = 16'h0000;
        n.ph   = 2'h0;
        n.rd   = rd;
        n.len  = len;
        n.rem  = len;
        n.step = 3'h0;
        n.err  = 1'b0;
      end
    end
    else if (!tick)
    begin
      n.qc = q.qc + 16'h0001;
    end
    else
    begin
      n.qc = 16'h0000;
      n.ph = q.ph + 2'h1;
      case (q.st)
        cfb_pkg::H_START:
        begin
          case (q.ph)
            2'h0: n.sdao = 1'b0;
            2'h1: n.sclo = 1'b0;
            2'h2: n.sdao = 1'b1;
            default:
            begin
              n.sclo = 1'b1;
              n.st   = cfb_pkg::H_BIT;
              n.bi   = 4'h0;
              n.rx   = 1'b0;
              n.nak  = 1'b0;
              n.sh   = hdr_byte(q.step, q.rd, q.len);
            end
          endcase
        end
        cfb_pkg::H_BIT:
        begin
          case (q.ph)
            2'h0:
            begin
              if (q.bi == 4'h8)
                n.sdao = q.rx && (q.rem > LEN_W'(1));
              else
                n.sdao = !q.rx && !q.sh[7];
            end
            2'h1: n.sclo = 1'b0;
            2'h2:
            begin
              if (q.bi != 4'h8 && q.rx)
                n.sh = {q.sh[6:0], bus.sda};
              if (q.bi == 4'h8 && !q.rx)
                n.nak = bus.sda;
            end
            default:
            begin
              n.sclo = 1'b1;
              n.bi   = q.bi + 4'h1;
              if (q.bi != 4'h8)
              begin
                if (!q.rx)
                  n.sh = {q.sh[6:0], 1'b0};
              end
              else
              begin
                n.bi  = 4'h0;
                n.nak = 1'b0;
                if (!q.rx && q.nak)
                begin
                  n.err = 1'b1;
                  n.st  = cfb_pkg::H_STOP;
                end
                else if (q.rx)
                begin
                  // empty read still takes one byte so target lets go
                  n.rdata  = q.sh;
                  n.rvalid = (q.rem != '0);
                  if (q.rem != '0)
                    n.rem = q.rem - LEN_W'(1);
                  if (q.rem <= LEN_W'(1))
                    n.st = cfb_pkg::H_STOP;
                end
                else if (q.step < 3'h2 || (q.step == 3'h2 && q.rd))
                begin
                  n.step = q.step + 3'h1;
                  n.sh   = hdr_byte(q.step + 3'h1, q.rd, q.len);
                  if (q.step == 3'h1 && q.rd)
                    n.st = cfb_pkg::H_START;
                end
                else if (q.rem == '0 && !q.rd)
                begin
                  n.st = cfb_pkg::H_STOP;
                end
                else if (q.rd)
                begin
                  n.rx   = 1'b1;
                  n.step = 3'h4;
                end
                else
                begin
                  n.step = 3'h3;
                  n.sh   = wdata;
                  n.take = 1'b1;
                  n.rem  = q.rem - LEN_W'(1);
                end
              end
            end
          endcase
        end
        cfb_pkg::H_STOP:
        begin
          case (q.ph)
            2'h0: n.sdao = 1'b1;
            2'h1: n.sclo = 1'b0;
            2'h2: n.sdao = 1'b0;
            default: n.st = cfb_pkg::H_IDLE;
          endcase
        end
        default: n.st = cfb_pkg::H_IDLE;
      endcase
    end
  end

  // all host state in one register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      q <= '0;
    else if (clk_en)
      q <= n;
  end

  assign bus.scl_o   = 1'b0;
  assign bus.scl_oe  = q.sclo;
  assign bus.hsda_o  = 1'b0;
  assign bus.hsda_oe = q.sdao;
  assign wtake       = q.take;
  assign rdata       = q.rdata;
  assign rvalid      = q.rvalid;
  assign busy        = (q.st != cfb_pkg::H_IDLE);
  assign nack_err    = q.err;

endmodule

// *** hdl/cfb_smb_if.sv ***
// Purpose: open-drain clock and data wires between host and device
// Assumes: each driver only ever pulls low
// Notes:   wire level is worked out here from the enables
`timescale 1ns/100ps
interface cfb_smb_if;
  logic scl_o;
  logic scl_oe;
  logic hsda_o;
  logic hsda_oe;
  logic dsda_o;
  logic dsda_oe;
  logic scl;
  logic sda;

  // wired-and with a pull-up: any enabled low driver wins
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((hsda_oe & ~hsda_o) | (dsda_oe & ~dsda_o));

  modport host (output scl_o, output scl_oe, output hsda_o,
                output hsda_oe, input scl, input sda);
  modport dev  (output dsda_o, output dsda_oe, input scl, input sda);
endinterface

// *** hdl/cfb_smb_regs.svh ***
// Purpose: shared constants of the block read/write serial link
// Assumes: one system clock at 100 MHz, serial lines open drain
// Notes:   counts are derived from the rates below
// How it works
// - block write fills registers from zero
// - host opens write with address, write bit
// - command code byte is all zeros
// - write byte count acknowledged, value ignored
// - data bytes land in successive registers
// - every data byte acknowledged before next
// - write bit clears the register pointer
// - read uses repeated start, read bit
// - repeated start keeps the pointer value
// - read byte count accepted then discarded
// - device sends registers in order from zero
// - host ends read with nack, stop
// - early nack makes device stop sending
// - link runs 10 to 400 kb/s
// - device answers only address 1101001
// - writes past last register wrap around
// - register updates at its acknowledge
// - ack low in ninth clock, else released
`ifndef CFB_SMB_REGS_SVH
`define CFB_SMB_REGS_SVH

`define CFB_DEV_ADDR      7'h69
`define CFB_CMD_CODE      8'h00
`define CFB_RW_WRITE      1'b0
`define CFB_RW_READ       1'b1
`define CFB_REG_RST       8'hFF
`define CFB_CLK_KHZ       100000
`define CFB_RATE_KBPS     100
`define CFB_RATE_MIN_KBPS 10
`define CFB_RATE_MAX_KBPS 400
`define CFB_QTR_CYC(k)    ((`CFB_CLK_KHZ + 4 * (k) - 1) / (4 * (k)))

`endif

// *** sim/cfb_smb_props.sv ***
// Purpose: protocol checks on the open-drain link between both ends
// Assumes: host built with QTR of 4, so scl lows last 8 clocks
// Notes:   sees only interface wires, never the user sides
`timescale 1ns/100ps
module cfb_smb_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic hsda_o,
  input wire logic hsda_oe,
  input wire logic dsda_o,
  input wire logic dsda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] nbit_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // rises since last start; saturates so long frames stay quiet
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      nbit_q <= 4'hf;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda)
        nbit_q <= 4'h0;
      else if (scl && !scl_q && nbit_q != 4'hf)
        nbit_q <= nbit_q + 4'h1;
    end
  end

  // bus conditions and the ninth clock of a frame's first byte
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence s_ninth_rise;
    $rose(scl) && nbit_q == 4'h8;
  endsequence

  a_rst_lines_free: assert property (
    $fell(sys_rst) |-> !scl_oe && !hsda_oe && !dsda_oe)
    else $error("lines not released after reset");
  a_pull_low_only: assert property (
    !(scl_oe && scl_o) && !(hsda_oe && hsda_o) && !(dsda_oe && dsda_o))
    else $error("a driver pushes a line high");
  a_dev_moves_low: assert property (
    $changed(dsda_oe) |-> !scl && !$past(scl))
    else $error("device moved sda while scl high");
  a_ack_held_high: assert property (
    $rose(scl) && dsda_oe |-> dsda_oe [*6])
    else $error("device drive dropped during clock high");
  a_addr_acked: assert property (
    s_ninth_rise |-> dsda_oe)
    else $error("own address not acknowledged");
  a_stop_released: assert property (
    s_stop |-> !dsda_oe)
    else $error("device still drives sda at stop");
  a_scl_low_time: assert property (
    $fell(scl) |-> !scl [*4] ##[1:8] scl)
    else $error("scl low time out of range");
  a_start_then_low: assert property (
    s_start |-> scl [*3] ##[1:6] !scl)
    else $error("scl did not fall after start");
endmodule

// *** sim/testbench.sv ***
// Purpose: block writes and reads from host user side into device
// Assumes: host QTR of 4 and three registers keep the run short
// Notes:   a second device on a hand-driven link takes bad frames
`timescale 1ns/100ps
module testbench;
  localparam int NR = 3;
  logic            clk;
  logic            sys_rst;
  logic            clk_en;
  logic            go;
  logic            rd;
  logic [5:0]      len;
  logic [7:0]      wdata;
  logic            wtake;
  logic [7:0]      rdata;
  logic            rvalid;
  logic            busy;
  logic            nack_err;
  logic [NR*8-1:0] regs;
  logic [NR*8-1:0] regs_b;
  logic            wr_stb;
  logic [1:0]      wr_idx;
  logic [7:0]      wq[$];
  logic [7:0]      rq[$];
  int              nstb;
  int              n_errors;
  int              checks;

  cfb_smb_if lnk ();
  cfb_smb_if bb ();

  cfb_smb_host #(.QTR(4)) u_cfb_smb_host (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus(lnk.host),
    .go(go), .rd(rd), .len(len), .wdata(wdata), .wtake(wtake),
    .rdata(rdata), .rvalid(rvalid), .busy(busy), .nack_err(nack_err));
  cfb_smb_dev #(.N_REGS(NR)) u_cfb_smb_dev (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus(lnk.dev),
    .bank(regs), .wr_stb(wr_stb), .wr_idx(wr_idx));
  // second device answers only the hand-driven link
  cfb_smb_dev #(.N_REGS(NR)) u_cfb_smb_dev_b (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus(bb.dev),
    .bank(regs_b), .wr_stb(), .wr_idx());
  cfb_smb_props u_cfb_smb_props (
    .clk(clk), .sys_rst(sys_rst), .scl_o(lnk.scl_o),
    .scl_oe(lnk.scl_oe), .hsda_o(lnk.hsda_o), .hsda_oe(lnk.hsda_oe),
    .dsda_o(lnk.dsda_o), .dsda_oe(lnk.dsda_oe), .scl(lnk.scl),
    .sda(lnk.sda));

  // free-running system clock
  always #5 clk = ~clk;

  task automatic give_verdict;
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] s);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one host transfer; feeds wq on wtake, gathers reads and strobes
  task automatic xfer(input logic r, input int n);
    int k;
    k = 0;
    nstb = 0;
    rq = {};
    @(posedge clk);
    rd <= r;
    len <= 6'(n);
    wdata <= (wq.size() > 0) ? wq[0] : 8'h00;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int t = 0; t < 30000 && (t == 0 || busy); t++)
    begin
      @(posedge clk);
      #1;
      if (rvalid)
        rq.push_back(rdata);
      if (wtake)
      begin
        k++;
        wdata <= (k < wq.size()) ? wq[k] : 8'h00;
      end
      if (wr_stb)
      begin
        chk("write index", 24'(nstb % NR), 24'(wr_idx));
        chk("reg at ack", 24'(wq[nstb]), 24'(regs[wr_idx*8+:8]));
        chk("busy at ack", 24'h1, 24'(busy));
        nstb++;
      end
    end
    chk("transfer ends", 24'h0, 24'(busy));
    if (busy)
      give_verdict();
  endtask

  // hand-driven wire step: hold levels for five clocks
  task automatic bb_step(input logic c, input logic d);
    @(posedge clk);
    bb.scl_oe <= ~c;
    bb.hsda_oe <= ~d;
    repeat (4) @(posedge clk);
  endtask

  // one byte msb first, then judge the ninth-clock acknowledge
  task automatic bb_send(input logic [7:0] v, input logic e,
                         input string nm);
    logic a;
    for (int i = 7; i >= 0; i--)
    begin
      bb_step(1'b0, v[i]);
      bb_step(1'b1, v[i]);
      bb_step(1'b0, v[i]);
    end
    bb_step(1'b0, 1'b1);
    bb_step(1'b1, 1'b1);
    #1;
    a = ~bb.sda;
    bb_step(1'b0, 1'b1);
    chk(nm, 24'(e), 24'(a));
  endtask

  task automatic bb_start;
    bb_step(1'b1, 1'b1);
    bb_step(1'b1, 1'b0);
    bb_step(1'b0, 1'b0);
  endtask

  task automatic bb_stop;
    bb_step(1'b0, 1'b0);
    bb_step(1'b1, 1'b0);
    bb_step(1'b1, 1'b1);
  endtask

  task automatic t_reset;
    chk("regs after reset", 24'hff_ffff, regs);
    chk("idle lines", 24'h3, {lnk.scl, lnk.sda});
  endtask

  // four bytes into three registers: last one wraps onto reg 0
  task automatic t_write;
    wq = '{8'ha1, 8'hb2, 8'hc3, 8'hd4};
    xfer(1'b0, 4);
    chk("strobes", 24'h4, 24'(nstb));
    chk("bank", 24'hc3_b2d4, regs);
    chk("nack flag", 24'h0, 24'(nack_err));
  endtask

  // full read runs past the last register and wraps
  task automatic t_read;
    xfer(1'b1, 4);
    chk("read count", 24'h4, 24'(rq.size()));
    chk("first three", 24'hd4_b2c3, {rq[0], rq[1], rq[2]});
    chk("wrapped byte", 24'hd4, 24'(rq[3]));
    chk("nack flag", 24'h0, 24'(nack_err));
    chk("sda released", 24'h1, {lnk.dsda_oe, lnk.sda});
  endtask

  // early stop, then write address must reset the pointer
  task automatic t_early_ptr;
    xfer(1'b1, 1);
    chk("short read", 24'h1_00d4, {8'(rq.size()), 8'h00, rq[0]});
    chk("device quiet", 24'h0, 24'(lnk.dsda_oe));
    wq = '{8'h11, 8'h22};
    xfer(1'b0, 2);
    xfer(1'b1, 3);
    chk("after reset ptr", 24'h11_22c3, {rq[0], rq[1], rq[2]});
  endtask

  // empty block write carries only the byte count; empty read also clocks one byte and drops it
  task automatic t_empty;
    wq = {};
    xfer(1'b0, 0);
    chk("empty strobes", 24'h0, 24'(nstb));
    chk("bank kept", 24'hc3_2211, regs);
    xfer(1'b1, 0);
    chk("empty read", 24'h0, 24'(rq.size() + nack_err));
    chk("empty read bus", 24'h1, {lnk.dsda_oe, lnk.sda});
  endtask

  // hand frames: foreign address, nonzero code, then a good write
  task automatic t_hand;
    bb_start();
    bb_send(8'hd0, 1'b0, "foreign address");
    bb_stop();
    bb_start();
    bb_send(8'hd2, 1'b1, "own address");
    bb_send(8'h01, 1'b0, "nonzero code");
    bb_send(8'h02, 1'b0, "after bad code");
    bb_stop();
    chk("bank untouched", 24'hff_ffff, regs_b);
    bb_start();
    bb_send(8'hd2, 1'b1, "own address");
    bb_send(8'h00, 1'b1, "zero code");
    bb_send(8'h20, 1'b1, "count 32");
    bb_send(8'h5a, 1'b1, "data 0");
    bb_send(8'h3c, 1'b1, "data 1");
    bb_stop();
    chk("hand bank", 24'hff_3c5a, regs_b);
  endtask

  // reset, then every scenario in turn
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    go = 1'b0;
    rd = 1'b0;
    len = 6'h00;
    wdata = 8'h00;
    bb.scl_o = 1'b0;
    bb.scl_oe = 1'b0;
    bb.hsda_o = 1'b0;
    bb.hsda_oe = 1'b0;
    n_errors = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_write();
    t_read();
    t_early_ptr();
    t_empty();
    t_hand();
    give_verdict();
  end
endmodule
